/* design/cal_mux_defines.vh */
// register offsets, field positions, reset values and timing constants for calibration and input mux config
`ifndef CAL_MUX_DEFINES_VH
`define CAL_MUX_DEFINES_VH
`define CAL_CFG_ADDR 8'h12
`define MUX_CFG_ADDR 8'h14
`define CAL_CFG_RESET 24'h004800
`define CAL_CFG_MASK 24'h707fff
`define MUX_CFG_RESET 24'h300000
`define MUX_CFG_MASK 24'hbf0000
`define CAL_ON_BIT 22
`define CAL_MODE_BIT 21
`define CAL_AMP_BIT 20
`define CAL_FREQ_HI 14
`define CAL_FREQ_LO 12
`define CAL_HALF_BIT 11
`define CAL_HIGH_HI 10
`define MUX_INV_BIT 23
`define MUX_POS_ISO_BIT 21
`define MUX_NEG_ISO_BIT 20
`define MUX_POS_RT_HI 19
`define MUX_POS_RT_LO 18
`define MUX_NEG_RT_HI 17
`define MUX_NEG_RT_LO 16
`define ROUTE_NONE 2'h0
`define ROUTE_MID 2'h1
`define ROUTE_POS_SRC 2'h2
`define ROUTE_NEG_SRC 2'h3
`define STEP_NS_00 16'd30520
`define STEP_NS_01 16'd31250
`define STEP_NS_10 16'd31250
`define STEP_NS_11 16'd31280
`define CLK_PERIOD_NS 16'd25
`endif

/* design/cal_source_input_mux_config.v */
// calibration source and input mux configuration registers with high time derivation
`timescale 1ns/1ps
`include "cal_mux_defines.vh"
module cal_source_input_mux_config (
  input wire core_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [23:0] reg_rdata,
  input wire [1:0] master_freq_sel,
  output wire cal_source_on,
  output wire cal_polarity_mode,
  output wire cal_amplitude_sel,
  output wire [2:0] cal_frequency_code,
  output wire half_duty_select,
  output wire [10:0] cal_high_time_count,
  output reg [26:0] high_time_ns,
  output reg [26:0] high_time_cycles,
  output wire [15:0] cal_time_step,
  output wire input_invert,
  output wire pos_input_isolate,
  output wire neg_input_isolate,
  output wire [1:0] pos_input_route,
  output wire [1:0] neg_input_route,
  output wire pos_to_mid,
  output wire pos_to_positive_test_source,
  output wire pos_to_negative_test_source,
  output wire neg_to_mid,
  output wire neg_to_positive_test_source,
  output wire neg_to_negative_test_source
);
  reg [23:0] cal_cfg;
  reg [23:0] mux_cfg;
  reg [1:0] freq_sync_a;
  reg [1:0] freq_sync_b;
  wire [15:0] step_cycles;

  // configuration register writes, unassigned bits forced to zero
  always @(posedge core_clk) begin
    if (!rst_b) begin
      cal_cfg <= `CAL_CFG_RESET;
      mux_cfg <= `MUX_CFG_RESET;
    end else if (reg_write) begin
      if (reg_addr == `CAL_CFG_ADDR)
        cal_cfg <= reg_wdata & `CAL_CFG_MASK;
      if (reg_addr == `MUX_CFG_ADDR)
        mux_cfg <= reg_wdata & `MUX_CFG_MASK;
    end
  end

  // read data in the cycle after the strobe, zero for unmapped addresses
  always @(posedge core_clk) begin
    if (!rst_b)
      reg_rdata <= 24'h000000;
    else if (reg_read && reg_addr == `CAL_CFG_ADDR)
      reg_rdata <= cal_cfg;
    else if (reg_read && reg_addr == `MUX_CFG_ADDR)
      reg_rdata <= mux_cfg;
    else
      reg_rdata <= 24'h000000;
  end

  // master frequency selection comes from another domain, two flops
  always @(posedge core_clk) begin
    if (!rst_b) begin
      freq_sync_a <= 2'h0;
      freq_sync_b <= 2'h0;
    end else begin
      freq_sync_a <= master_freq_sel;
      freq_sync_b <= freq_sync_a;
    end
  end

  cal_time_step u_step (
    .master_freq_sel(freq_sync_b),
    .step_ns(cal_time_step),
    .step_cycles(step_cycles)
  );

  // field views of the calibration register
  assign cal_source_on = cal_cfg[`CAL_ON_BIT];
  assign cal_polarity_mode = cal_cfg[`CAL_MODE_BIT];
  assign cal_amplitude_sel = cal_cfg[`CAL_AMP_BIT];
  assign cal_frequency_code = cal_cfg[`CAL_FREQ_HI:`CAL_FREQ_LO];
  assign half_duty_select = cal_cfg[`CAL_HALF_BIT];
  assign cal_high_time_count = cal_cfg[`CAL_HIGH_HI:0];

  // programmed high time; zero means half-period mode, decoded by the generator
  always @(posedge core_clk) begin
    if (!rst_b) begin
      high_time_ns <= 27'h0000000;
      high_time_cycles <= 27'h0000000;
    end else if (half_duty_select) begin
      high_time_ns <= 27'h0000000;
      high_time_cycles <= 27'h0000000;
    end else begin
      high_time_ns <= {16'h0000, cal_high_time_count} * {11'h000, cal_time_step};
      high_time_cycles <= {16'h0000, cal_high_time_count} * {11'h000, step_cycles};
    end
  end

  // field views of the mux register
  assign input_invert = mux_cfg[`MUX_INV_BIT];
  assign pos_input_isolate = mux_cfg[`MUX_POS_ISO_BIT];
  assign neg_input_isolate = mux_cfg[`MUX_NEG_ISO_BIT];
  assign pos_input_route = mux_cfg[`MUX_POS_RT_HI:`MUX_POS_RT_LO];
  assign neg_input_route = mux_cfg[`MUX_NEG_RT_HI:`MUX_NEG_RT_LO];

  input_route_decode u_pos (
    .route(pos_input_route),
    .cal_on(cal_source_on),
    .to_mid(pos_to_mid),
    .to_pos_src(pos_to_positive_test_source),
    .to_neg_src(pos_to_negative_test_source)
  );

  input_route_decode u_neg (
    .route(neg_input_route),
    .cal_on(cal_source_on),
    .to_mid(neg_to_mid),
    .to_pos_src(neg_to_positive_test_source),
    .to_neg_src(neg_to_negative_test_source)
  );
endmodule

/* design/cal_time_step.v */
// calibration time step lookup from master frequency selection, in ns and core clock cycles
`timescale 1ns/1ps
`include "cal_mux_defines.vh"
module cal_time_step (
  input wire [1:0] master_freq_sel,
  output reg [15:0] step_ns,
  output wire [15:0] step_cycles
);
  // resolution per master frequency selection
  always @* begin
    case (master_freq_sel)
      2'h0: step_ns = `STEP_NS_00;
      2'h1: step_ns = `STEP_NS_01;
      2'h2: step_ns = `STEP_NS_10;
      2'h3: step_ns = `STEP_NS_11;
      default: step_ns = `STEP_NS_00;
    endcase
  end
  // whole clock cycles per step, rounded down, at least one
  assign step_cycles = (step_ns / `CLK_PERIOD_NS == 16'h0000) ? 16'h0001 : step_ns / `CLK_PERIOD_NS;
endmodule

/* design/input_route_decode.v */
// decodes one input's route code into switch controls
`timescale 1ns/1ps
`include "cal_mux_defines.vh"
module input_route_decode (
  input wire [1:0] route,
  input wire cal_on,
  output wire to_mid,
  output wire to_pos_src,
  output wire to_neg_src
);
  // source routes connect only while calibration is enabled
  assign to_mid = (route == `ROUTE_MID);
  assign to_pos_src = (route == `ROUTE_POS_SRC) & cal_on;
  assign to_neg_src = (route == `ROUTE_NEG_SRC) & cal_on;
endmodule

/* tb/cal_mux_assertions.sv */
// port assertions for the calibration and mux configuration block
`timescale 1ns/1ps
module cal_mux_checker (
  input core_clk,
  input rst_b,
  input [7:0] reg_addr,
  input [23:0] reg_wdata,
  input reg_write,
  input reg_read,
  input [23:0] reg_rdata,
  input [1:0] master_freq_sel,
  input [15:0] cal_time_step,
  input cal_source_on,
  input half_duty_select,
  input [26:0] high_time_ns,
  input pos_input_isolate,
  input [1:0] pos_input_route,
  input pos_to_positive_test_source
);
  // one clock domain for every check
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(a); reg_write && reg_addr == a; endsequence
  sequence s_rd(a); reg_read && reg_addr == a; endsequence
  property p_on; s_wr(8'h12) |=> cal_source_on == $past(reg_wdata[22]); endproperty
  a_on: assert property (p_on) else $error("enable not taken");
  property p_iso; s_wr(8'h14) |=> pos_input_isolate == $past(reg_wdata[21]); endproperty
  a_iso: assert property (p_iso) else $error("isolate not taken");
  property p_idle; !$past(reg_read) |-> reg_rdata == 24'h000000; endproperty
  a_idle: assert property (p_idle) else $error("read data not cleared");
  property p_rcal; s_rd(8'h12) |=> (reg_rdata & 24'h8f8000) == 24'h000000; endproperty
  a_rcal: assert property (p_rcal) else $error("cal spare bits set");
  property p_rmux; s_rd(8'h14) |=> (reg_rdata & 24'h40ffff) == 24'h000000; endproperty
  a_rmux: assert property (p_rmux) else $error("mux spare bits set");
  property p_half; half_duty_select |=> high_time_ns == 27'h0000000; endproperty
  a_half: assert property (p_half) else $error("half duty count used");
  property p_step; master_freq_sel == 2'h0 [*4] |-> cal_time_step == 16'd30520; endproperty
  a_step: assert property (p_step) else $error("step wrong");
  property p_src; pos_to_positive_test_source == (pos_input_route == 2'h2 && cal_source_on); endproperty
  a_src: assert property (p_src) else $error("source route gating");
endmodule
bind cal_source_input_mux_config cal_mux_checker cal_mux_checker_inst (.*);

/* tb/tb_top.sv */
// bench for the calibration and mux configuration registers
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, rst_b = 0, reg_write = 0, reg_read = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000, reg_rdata;
  logic [1:0] master_freq_sel = 2'h0, pos_input_route, neg_input_route;
  logic [2:0] cal_frequency_code;
  logic [10:0] cal_high_time_count;
  logic [26:0] high_time_ns, high_time_cycles;
  logic [15:0] cal_time_step;
  logic cal_source_on, cal_polarity_mode, cal_amplitude_sel, half_duty_select, input_invert;
  logic pos_input_isolate, neg_input_isolate, pos_to_mid, neg_to_mid;
  logic pos_to_positive_test_source, pos_to_negative_test_source;
  logic neg_to_positive_test_source, neg_to_negative_test_source;
  int num_errors = 0, n_compared = 0;
  logic [55:0] rows [5] = '{56'h12ffffff707fff, 56'h12000000000000, 56'h14ffffffbf0000,
                           56'h14000000000000, 56'h10ffffff000000};
  int ns [4] = '{30520, 31250, 31250, 31280};
  int cyc [4] = '{1220, 1250, 1250, 1251};
  cal_source_input_mux_config cal_source_input_mux_config_inst (.*);
  // free-running core clock
  initial forever #12.5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    #20000;
    num_errors++;
    final_report;
  end
  // main test sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][55:48], rows[i][47:24]);
      rd(rows[i][55:48], rows[i][23:0]);
    end
    $display("register table test done");
    wr(8'h12, 24'h000000);
    wr(8'h14, 24'hbb0000);
    chk("src off", 0, {pos_to_positive_test_source, neg_to_negative_test_source});
    wr(8'h12, 24'h700000);
    chk("fields", 7'h7d, {cal_source_on, cal_polarity_mode, cal_amplitude_sel, pos_to_positive_test_source,
      neg_to_negative_test_source, pos_to_negative_test_source, input_invert});
    wr(8'h14, 24'h050000);
    chk("mid", 9'h185, {pos_to_mid, neg_to_mid, pos_input_isolate, neg_input_isolate, input_invert,
      pos_input_route, neg_input_route});
    wr(8'h14, 24'h0e0000);
    chk("cross", 2'h3, {pos_to_negative_test_source, neg_to_positive_test_source});
    $display("routing test done");
    wr(8'h12, 24'h0007ff);
    chk("cal_high_time_count", 11'h7ff, cal_high_time_count);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      master_freq_sel <= i[1:0];
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      chk("cal_time_step", ns[i], cal_time_step);
      chk("high_time_ns", 2047 * ns[i], high_time_ns);
      chk("high_time_cycles", 2047 * cyc[i], high_time_cycles);
    end
    wr(8'h12, 24'h000fff);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("half high", 0, high_time_ns);
    $display("high time test done");
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(8'h12, 24'h004800);
    rd(8'h14, 24'h300000);
    chk("reset fields", 15'h4800, {cal_frequency_code, half_duty_select, cal_high_time_count});
    $display("reset test done");
    final_report;
  end
endmodule
